// [logic/ppp_defs.svh]
// constants for the printer parallel port pin block
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

// clock period and strobe timing
`define PPP_CLK_NS       100
`define PPP_STROBE_NS    500
`define PPP_STROBE_CYC   ((`PPP_STROBE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)

// command word layout in the fifo
`define PPP_CMD_W        10
`define PPP_CMD_WR_BIT   9
`define PPP_CMD_AD_BIT   8
`define PPP_FIFO_DEPTH   4

// positions in the synchronised pin vector
`define PPP_SY_BUSY      0
`define PPP_SY_ACK       1
`define PPP_SY_ERR       2
`define PPP_SY_PE        3
`define PPP_SY_ONL       4
`define PPP_SY_DLO       5
`define PPP_SY_DHI       12
`define PPP_SY_W         13

// reset values
`define PPP_RST_BUF_OE   1'b1

`endif

// [logic/ppp_pkg.sv]
// types of the printer parallel port pin block
`include "ppp_defs.svh"
package ppp_pkg;

    // transfer sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD   = 5'h08,
        ST_ERR    = 5'h10
    } ppp_state_e;

    // whole state of the port module
    typedef struct packed {
        logic [`PPP_SY_W-1:0] sy1;
        logic [`PPP_SY_W-1:0] sy2;
        ppp_state_e           st;
        logic                 epp;
        logic                 bidir;
        logic                 is_write;
        logic                 is_addr;
        logic [3:0]           cnt;
        logic [7:0]           dat;
        logic                 init;
        logic                 sel;
        logic                 stb;
        logic                 alf;
        logic                 lwe;
        logic                 boe;
        logic [7:0]           pdo;
        logic                 busy;
        logic                 ack;
        logic                 irq;
        logic                 err;
        logic                 pe;
        logic                 onl;
        logic                 rdv;
        logic [7:0]           rdd;
        logic                 act;
    } ppp_main_s;

endpackage : ppp_pkg

// [logic/ppp_fifo.sv]
// command fifo with registered read data
`timescale 1ns/100ps
module ppp_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_reset_n,
    input  wire logic         i_valid,
    input  wire logic [W-1:0] i_data,
    output logic              o_ready,
    output logic              o_valid,
    output logic [W-1:0]      o_data,
    input  wire logic         i_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                rdy;
        logic [W-1:0]        out;
        logic                ov;
    } ppp_fifo_s;

    ppp_fifo_s s;
    ppp_fifo_s next_s;

    ////////////////////////////////////////////////////////////////////
    // push, pop into the output register, level count
    always_comb
    begin
        logic push;
        logic pop;
        push   = 1'b0;
        pop    = 1'b0;
        next_s = s;
        push   = i_valid && s.rdy;
        if (i_ready && s.ov)
            next_s.ov = 1'b0;
        if (!next_s.ov && s.cnt != '0)
        begin
            next_s.out = s.mem[s.rp];
            next_s.ov  = 1'b1;
            next_s.rp  = s.rp + 1'b1; // depth is a power of two
            pop        = 1'b1;
        end
        if (push)
        begin
            next_s.mem[s.wp] = i_data;
            next_s.wp        = s.wp + 1'b1;
        end
        if (push && !pop)
            next_s.cnt = s.cnt + 1'b1;
        else if (!push && pop)
            next_s.cnt = s.cnt - 1'b1;
        // ready from a flop: no combinational path back to the source
        next_s.rdy = (next_s.cnt != (AW+1)'(D));
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s     <= '0;
            s.rdy <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign o_ready = s.rdy;
    assign o_valid = s.ov;
    assign o_data  = s.out;

endmodule : ppp_fifo

// [logic/ppp_port.sv]
// printer parallel port pin sequencer, standard and epp modes
//
// Notes on behaviour
// - epp mode: wait pin adds wait states to the running cycle.
// - an output tells the printer to start its initialisation.
// - unidirectional: latch enable loads the data byte into external latch.
// - bidirectional: latch enable becomes data port address decode.
// - bidirectional: buffer enable on while driving, off while reading.
// - standard mode: select output selects the attached peripheral.
// - epp mode: address strobe only during address register accesses.
// - standard mode: strobe pulse makes peripheral latch the data lines.
// - epp mode: write indication during writes, inactive during reads.
// - ack pin is acknowledge in standard mode, interrupt in epp.
// - auto linefeed in standard mode, data strobe in epp mode.
`timescale 1ns/100ps
`include "ppp_defs.svh"
module ppp_port (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic       i_mode_epp,
    input  wire logic       i_bidir,
    input  wire logic       i_init_req,
    input  wire logic       i_select_req,
    input  wire logic       i_linefeed_req,
    input  wire logic       i_cmd_valid,
    input  wire logic       i_cmd_write,
    input  wire logic       i_cmd_addr,
    input  wire logic [7:0] i_cmd_data,
    output logic            o_cmd_ready,
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_data,
    output logic            o_xfer_busy,
    input  wire logic       i_busy_wait,
    input  wire logic       i_ack_intr,
    input  wire logic       i_error,
    input  wire logic       i_no_paper_flag,
    input  wire logic       i_printer_online_in,
    input  wire logic [7:0] i_port_data,
    output logic            o_init_printer,
    output logic            o_select_printer_out,
    output logic            o_data_latch_strobe,
    output logic            o_auto_linefeed,
    output logic            o_port_data_latch_we,
    output logic            o_port_out_buf_oe,
    output logic [7:0]      o_port_data,
    output logic            o_printer_busy,
    output logic            o_printer_ack,
    output logic            o_epp_irq,
    output logic            o_printer_error,
    output logic            o_no_paper,
    output logic            o_printer_online
);
    ppp_pkg::ppp_main_s           s;
    ppp_pkg::ppp_main_s           next_s;
    logic                         f_valid;
    logic [`PPP_CMD_W-1:0]        f_data;
    logic                         f_ready;

    ////////////////////////////////////////////////////////////////////
    // command buffer; the sequencer only drains it while idle
    assign f_ready = (s.st == ppp_pkg::ST_IDLE);

    ppp_fifo #(
        .W (`PPP_CMD_W),
        .D (`PPP_FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_valid   (i_cmd_valid),
        .i_data    ({i_cmd_write, i_cmd_addr, i_cmd_data}),
        .o_ready   (o_cmd_ready),
        .o_valid   (f_valid),
        .o_data    (f_data),
        .i_ready   (f_ready)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencer and pin mapping
    always_comb
    begin
        logic act;
        logic acc;
        logic wait_s;
        act    = 1'b0;
        acc    = 1'b0;
        wait_s = 1'b0;
        next_s = s;
        // pins cross in through two flops before any use
        next_s.sy1 = {i_port_data, i_printer_online_in, i_no_paper_flag,
                      i_error, i_ack_intr, i_busy_wait};
        next_s.sy2 = s.sy1;
        wait_s     = s.sy2[`PPP_SY_BUSY];
        next_s.rdv = 1'b0;

        unique case (s.st)
            ppp_pkg::ST_IDLE:
            begin
                // mode only changes between transfers, never mid-cycle
                next_s.epp   = i_mode_epp;
                next_s.bidir = i_bidir;
                if (f_valid)
                begin
                    next_s.is_write = f_data[`PPP_CMD_WR_BIT];
                    next_s.is_addr  = f_data[`PPP_CMD_AD_BIT];
                    next_s.dat      = f_data[7:0];
                    next_s.st       = ppp_pkg::ST_SETUP;
                end
            end
            ppp_pkg::ST_SETUP:
            begin
                next_s.cnt = 4'(`PPP_STROBE_CYC - 1);
                next_s.st  = ppp_pkg::ST_STROBE;
            end
            ppp_pkg::ST_STROBE:
            begin
                // both modes hold the full width first; this also covers
                // the two sync flops ahead of a wait raised at strobe start
                if (s.cnt != 4'h0)
                    next_s.cnt = s.cnt - 4'h1;
                else if (!(s.epp && wait_s))
                    next_s.st = ppp_pkg::ST_HOLD;
            end
            ppp_pkg::ST_HOLD:
            begin
                if (!s.is_write)
                begin
                    next_s.rdv = 1'b1;
                    next_s.rdd = s.sy2[`PPP_SY_DHI:`PPP_SY_DLO];
                end
                next_s.st = ppp_pkg::ST_IDLE;
            end
            default:
                next_s.st = ppp_pkg::ST_IDLE; // illegal one-hot code
        endcase

        act = (next_s.st != ppp_pkg::ST_IDLE);
        acc = (next_s.st == ppp_pkg::ST_STROBE);
        next_s.act  = act;
        next_s.pdo  = next_s.dat;
        next_s.init = i_init_req;

        // shared pins take their meaning from the mode
        if (next_s.epp)
        begin
            next_s.sel = acc && next_s.is_addr;
            next_s.alf = acc && !next_s.is_addr;
            next_s.stb = act && next_s.is_write;
        end
        else
        begin
            next_s.sel = i_select_req;
            next_s.alf = i_linefeed_req;
            next_s.stb = acc && next_s.is_write;
        end

        // external latch and buffer controls
        if (next_s.bidir)
            next_s.lwe = act && !next_s.is_addr;
        else
            next_s.lwe = (next_s.st == ppp_pkg::ST_SETUP)
                         && next_s.is_write;
        next_s.boe = !(next_s.bidir && act && !next_s.is_write);

        // status pins; busy, ack and irq set by mode, error, paper and online pass through
        next_s.busy = !next_s.epp && s.sy2[`PPP_SY_BUSY];
        next_s.ack  = !next_s.epp && s.sy2[`PPP_SY_ACK];
        next_s.irq  = next_s.epp && s.sy2[`PPP_SY_ACK];
        next_s.err  = s.sy2[`PPP_SY_ERR];
        next_s.pe   = s.sy2[`PPP_SY_PE];
        next_s.onl  = s.sy2[`PPP_SY_ONL];
    end

    // async reset to constants only
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s     <= '0;
            s.st  <= ppp_pkg::ST_IDLE;
            s.boe <= `PPP_RST_BUF_OE;
        end
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the state flops
    assign o_rd_valid           = s.rdv;
    assign o_rd_data            = s.rdd;
    assign o_xfer_busy          = s.act;
    assign o_init_printer       = s.init;
    assign o_select_printer_out = s.sel;
    assign o_data_latch_strobe  = s.stb;
    assign o_auto_linefeed      = s.alf;
    assign o_port_data_latch_we = s.lwe;
    assign o_port_out_buf_oe    = s.boe;
    assign o_port_data          = s.pdo;
    assign o_printer_busy       = s.busy;
    assign o_printer_ack        = s.ack;
    assign o_epp_irq            = s.irq;
    assign o_printer_error      = s.err;
    assign o_no_paper           = s.pe;
    assign o_printer_online     = s.onl;

    ////////////////////////////////////////////////////////////////////
    // checks on the pin sequencing
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    a_addr_strobe_only: assert property (
        s.epp && o_select_printer_out
        |-> s.st == ppp_pkg::ST_STROBE && s.is_addr)
        else $error("address strobe outside an address access");

    a_write_ind_read: assert property (
        s.epp && s.act && !s.is_write |-> !o_data_latch_strobe)
        else $error("write indication during a read");

    a_write_ind_span: assert property (
        s.epp && $rose(o_xfer_busy) && s.is_write
        |-> o_data_latch_strobe throughout
            (o_xfer_busy ##1 o_xfer_busy ##1 o_xfer_busy))
        else $error("write indication dropped inside a write");

    a_wait_holds: assert property (
        s.epp && s.st == ppp_pkg::ST_STROBE && s.sy2[`PPP_SY_BUSY]
        |=> s.st == ppp_pkg::ST_STROBE
            && (o_select_printer_out || o_auto_linefeed))
        else $error("cycle ended while wait asserted");

    a_wait_release: assert property (
        s.epp && s.st == ppp_pkg::ST_STROBE && !s.sy2[`PPP_SY_BUSY]
        && s.cnt == 4'h0
        |=> s.st == ppp_pkg::ST_HOLD ##1 s.st == ppp_pkg::ST_IDLE)
        else $error("cycle did not finish after wait dropped");

    a_std_strobe: assert property (
        !s.epp && $rose(o_data_latch_strobe)
        |-> o_data_latch_strobe [*5] ##1 !o_data_latch_strobe)
        else $error("standard strobe width wrong");

    a_latch_pulse: assert property (
        !s.bidir && $rose(o_port_data_latch_we)
        |=> !o_port_data_latch_we && o_data_latch_strobe)
        else $error("latch enable not a pulse before strobe");

    a_data_decode: assert property (
        s.bidir && s.act && !s.is_addr |-> o_port_data_latch_we)
        else $error("data port decode missing");

    a_buf_oe_read: assert property (
        s.bidir && s.act |-> o_port_out_buf_oe == s.is_write)
        else $error("output buffer enable wrong for direction");

    a_linefeed_std: assert property (
        !s.epp && !$past(s.epp) |-> o_auto_linefeed == $past(i_linefeed_req))
        else $error("linefeed does not follow request");

    a_init_follow: assert property (
        $past(i_reset_n) |-> o_init_printer == $past(i_init_req))
        else $error("init output does not follow request");

    a_read_return: assert property (
        s.st == ppp_pkg::ST_HOLD && !s.is_write |=> o_rd_valid)
        else $error("read data not returned");

    // status outputs trail their pins by the two sync flops and one more
    a_busy_std: assert property (
        $past(i_reset_n, 3)
        |-> o_printer_busy == (!s.epp && $past(i_busy_wait, 3)))
        else $error("busy status does not follow the pin");

    a_ack_std: assert property (
        $past(i_reset_n, 3)
        |-> o_printer_ack == (!s.epp && $past(i_ack_intr, 3)))
        else $error("acknowledge status does not follow the pin");

    a_irq_epp: assert property (
        $past(i_reset_n, 3)
        |-> o_epp_irq == (s.epp && $past(i_ack_intr, 3)))
        else $error("interrupt request does not follow the pin");

    a_error_pass: assert property (
        $past(i_reset_n, 3)
        |-> o_printer_error == $past(i_error, 3))
        else $error("error status does not follow the pin");

    a_paper_pass: assert property (
        $past(i_reset_n, 3)
        |-> o_no_paper == $past(i_no_paper_flag, 3))
        else $error("no paper status does not follow the pin");

    a_online_pass: assert property (
        $past(i_reset_n, 3)
        |-> o_printer_online == $past(i_printer_online_in, 3))
        else $error("online status does not follow the pin");

    a_select_std: assert property (
        !s.epp && $past(i_reset_n)
        |-> o_select_printer_out == $past(i_select_req))
        else $error("select output does not follow request");

    a_buf_uni: assert property (
        !s.bidir |-> o_port_out_buf_oe)
        else $error("output buffer disabled in unidirectional use");

    c_std_write: cover property (
        !s.epp && $rose(o_data_latch_strobe));
    c_epp_addr_wr: cover property (
        s.epp && o_select_printer_out && o_data_latch_strobe);
    c_epp_read_wait: cover property (
        s.epp && o_auto_linefeed && s.sy2[`PPP_SY_BUSY] ##[1:40] o_rd_valid);
    c_fifo_full: cover property (!o_cmd_ready);

endmodule : ppp_port

// [sim/ppp_printer_model.sv]
// behavioural printer or epp peripheral on the far side of the port
`timescale 1ns/100ps
module ppp_printer_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_mode_epp,
    input  wire logic       i_select_out,
    input  wire logic       i_write_ind,
    input  wire logic       i_linefeed,
    input  wire logic       i_buf_oe,
    input  wire logic [7:0] i_port_data,
    input  wire logic       i_busy,
    input  wire logic       i_ack,
    input  wire logic       i_paper_out,
    input  wire logic       i_fault,
    input  wire logic [3:0] i_wait_cyc,
    input  wire logic [7:0] i_rd_byte,
    output logic            o_busy_wait,
    output logic            o_ack_intr,
    output logic            o_error,
    output logic            o_no_paper,
    output logic            o_online,
    output logic [7:0]      o_port_data
);
    logic [3:0] cnt;
    logic       stb_on;

    // epp strobe seen: address strobe or data strobe
    assign stb_on = i_mode_epp & (i_select_out | i_linefeed);

    // count strobe cycles to know when to release wait
    always_ff @(posedge i_clk_sys)
    begin
        cnt <= (stb_on && cnt != 4'hf) ? cnt + 4'h1 : (stb_on ? cnt : 4'h0);
    end

    // wait stretches the running epp cycle
    assign o_busy_wait = i_mode_epp ? (stb_on & (cnt < i_wait_cyc))
                                    : i_busy;
    assign o_ack_intr  = i_ack;
    assign o_online    = i_select_out;
    assign o_no_paper  = i_paper_out;
    assign o_error     = ~o_online | i_paper_out | i_fault;
    // buffer off on a read means the peripheral owns the lines
    assign o_port_data = (i_buf_oe | i_write_ind) ? i_port_data : i_rd_byte;
endmodule : ppp_printer_model

// [sim/tb_top.sv]
// self-checking bench for the parallel port pin sequencer
`timescale 1ns/100ps
`include "ppp_defs.svh"
module tb_top;
    logic       clk = 0, rst_n = 0, epp = 0, bidir = 0;
    logic       init = 0, sel = 0, lf = 0, cv = 0, cw = 0, ca = 0;
    logic [7:0] cd = 8'h00, rd_byte = 8'h00, pd_in, pd_out, rd_got;
    logic       busy = 0, ack = 0, paper = 0, fault = 0, rd_seen;
    logic [3:0] wcyc = 4'h0;
    logic       rdy, rdv, xb, w_bw, w_ack, w_err, w_np, w_onl;
    logic       o_init, o_sel, o_stb, o_alf, o_lwe, o_oe, o_busy;
    logic       o_ack, o_irq, o_err, o_np, o_onl;
    logic [7:0] rdd;
    logic [4:0] lv;
    int         run[5], wid[5], n_stb, cyc, err_total, comparisons;

    always #50 clk = ~clk;

    ppp_port DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_mode_epp(epp),
        .i_bidir(bidir), .i_init_req(init), .i_select_req(sel),
        .i_linefeed_req(lf), .i_cmd_valid(cv), .i_cmd_write(cw),
        .i_cmd_addr(ca), .i_cmd_data(cd), .o_cmd_ready(rdy),
        .o_rd_valid(rdv), .o_rd_data(rdd), .o_xfer_busy(xb),
        .i_busy_wait(w_bw), .i_ack_intr(w_ack), .i_error(w_err),
        .i_no_paper_flag(w_np), .i_printer_online_in(w_onl),
        .i_port_data(pd_in), .o_init_printer(o_init),
        .o_select_printer_out(o_sel), .o_data_latch_strobe(o_stb),
        .o_auto_linefeed(o_alf), .o_port_data_latch_we(o_lwe),
        .o_port_out_buf_oe(o_oe), .o_port_data(pd_out),
        .o_printer_busy(o_busy), .o_printer_ack(o_ack), .o_epp_irq(o_irq),
        .o_printer_error(o_err), .o_no_paper(o_np),
        .o_printer_online(o_onl));

    ppp_printer_model PRN (.i_clk_sys(clk), .i_mode_epp(epp),
        .i_select_out(o_sel), .i_write_ind(o_stb), .i_linefeed(o_alf),
        .i_buf_oe(o_oe), .i_port_data(pd_out), .i_busy(busy),
        .i_ack(ack), .i_paper_out(paper), .i_fault(fault),
        .i_wait_cyc(wcyc), .i_rd_byte(rd_byte), .o_busy_wait(w_bw),
        .o_ack_intr(w_ack), .o_error(w_err), .o_no_paper(w_np),
        .o_online(w_onl), .o_port_data(pd_in));

    // pulse widths of the pins, measured between edges
    assign lv = {~o_oe, o_lwe, o_alf, o_sel, o_stb};
    always @(negedge clk)
    begin
        cyc++;
        if (rdv === 1'b1) begin rd_seen = 1; rd_got = rdd; end
        for (int i = 0; i < 5; i++)
            if (lv[i] === 1'b1) run[i]++;
            else begin
                if (run[i] > 0) wid[i] = run[i];
                if (i == 0 && run[0] > 0) n_stb++;
                run[i] = 0;
            end
        if (cyc == 20000) begin err_total++; conclude(); end // hang cut
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task conclude;
        $display("mismatches=%0d compares=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    // one command, held until ready was seen ahead of the taking edge
    task send(input logic w, input logic a, input logic [7:0] d);
        @(negedge clk);
        {cv, cw, ca, cd} = {1'b1, w, a, d};
        while (rdy !== 1'b1) @(negedge clk);
        @(negedge clk);
        cv = 0;
    endtask : send

    // idle for several cycles means queue and sequencer are empty
    task quiet;
        int n;
        n = 0;
        while (n < 4) begin @(negedge clk); n = (xb === 1'b0) ? n + 1 : 0; end
    endtask : quiet

    // wait until quiet, then forget the widths of earlier pulses
    task settle;
        quiet();
        for (int i = 0; i < 5; i++) wid[i] = 0;
    endtask : settle

    task t_reset;
        check({o_oe, rdy, xb, o_stb, o_sel, o_lwe, rdv}, 16'h60);
    endtask : t_reset

    task t_std_write;
        send(1, 0, 8'ha5);
        settle();
        send(1, 0, 8'h5a);
        while (o_lwe !== 1'b1) @(negedge clk);
        check(pd_out, 8'h5a);
        @(negedge clk);
        check(o_stb, 1);
        quiet();
        check(wid[0], `PPP_STROBE_CYC);
        check(wid[3], 1);
    endtask : t_std_write

    task t_levels;
        {init, sel, lf, paper, busy} = 5'h1f;
        repeat (4) @(negedge clk);
        check({o_init, o_sel, o_alf}, 3'h7);
        check({o_onl, o_np, o_err, o_busy}, 4'hf);
        {sel, paper, busy} = 3'h0;
        repeat (4) @(negedge clk);
        check({o_onl, o_np, o_err, o_busy}, 4'h2);
        {init, lf, sel} = 3'h1;
        repeat (4) @(negedge clk);
    endtask : t_levels

    task t_mode;
        ack = 1;
        repeat (4) @(negedge clk);
        check({o_ack, o_irq}, 2'h2);
        {epp, busy} = 2'h3;
        repeat (4) @(negedge clk);
        check({o_ack, o_irq, o_busy}, 3'h2);
        ack = 0;
        settle();
    endtask : t_mode

    // slow peripheral holds wait for six cycles on an address write
    task t_epp_addr;
        wcyc = 4'h6;
        send(1, 1, 8'h3c);
        quiet();
        check(wid[1] >= 6, 1);
        check(wid[0] > wid[1], 1);
        check(wid[2], 0);
    endtask : t_epp_addr

    // bidirectional data read, prompt peripheral
    task t_epp_read;
        {bidir, wcyc, rd_byte, rd_seen} = {1'b1, 4'h0, 8'hc3, 1'b0};
        settle();
        send(0, 0, 8'h00);
        quiet();
        check({rd_seen, rd_got}, 9'h1c3);
        check(wid[2] >= 1, 1);
        check(wid[0] + wid[1], 0);
        check(wid[4] >= wid[2], 1);
        check(wid[3] >= wid[2], 1);
        epp = 0;
        settle();
        // standard mode read on the bidirectional arrangement
        {rd_byte, rd_seen} = {8'h96, 1'b0};
        send(0, 0, 8'h00);
        quiet();
        check({rd_seen, rd_got}, 9'h196);
        check(wid[0] + wid[2], 0);
        check(wid[4] >= 5, 1);
        bidir = 0;
        settle();
    endtask : t_epp_read

    // keep offering for twelve cycles, through the queue refusing, then drain it
    task t_fifo;
        int acc, n0;
        logic refused;
        {acc, refused, n0} = {32'h0, 1'b0, n_stb};
        @(negedge clk);
        {cv, cw, ca, cd} = {3'h6, 8'h77};
        repeat (12)
        begin
            if (rdy === 1'b1) acc++;
            else refused = 1;
            @(negedge clk);
        end
        cv = 0;
        settle();
        check(refused, 1);
        check(n_stb - n0, acc);
    endtask : t_fifo

    initial
    begin
        repeat (4) @(negedge clk);
        t_reset();
        repeat (4) @(negedge clk);
        rst_n = 1;
        t_std_write();
        t_levels();
        t_mode();
        t_epp_addr();
        t_epp_read();
        t_fifo();
        conclude();
    end
endmodule : tb_top
